// file: hdl/itfd_map.vh
// Register offsets, field positions, reset values and timing counts of the terminal dispatcher
`ifndef ITFD_MAP_VH
`define ITFD_MAP_VH

// Byte offsets on the register bus
`define ITFD_OFS_CTRL      8'h00
`define ITFD_OFS_FILTER    8'h04
`define ITFD_OFS_LEVELS    8'h08
`define ITFD_OFS_EVCNT     8'h0c
`define ITFD_OFS_LENGTH    8'h10
`define ITFD_OFS_FAULT     8'h14
`define ITFD_OFS_REQS      8'h18
`define ITFD_OFS_FSEL_BASE 8'h40

// Control register fields
`define ITFD_CTRL_CMDSRC_LSB 0
`define ITFD_CTRL_CMDSRC_MSB 1
`define ITFD_CTRL_PIDSRC     2
`define ITFD_CTRL_RTA        3
`define ITFD_CTRL_RTB        4
`define ITFD_CTRL_EXTACT_LSB 8
`define ITFD_CTRL_EXTACT_MSB 9
`define ITFD_CTRL_USRACT_LSB 10
`define ITFD_CTRL_USRACT_MSB 11
`define ITFD_CTRL_RESET      32'h0000_0000

// Command source encodings
`define ITFD_CMDSRC_KEYPAD 2'h0

// Filter time in milliseconds: default 0.010 s, ceiling 1.000 s
`define ITFD_FILT_MS_RESET 10'h00a
`define ITFD_FILT_MS_MAX   10'h3e8

// Clock 200 MHz, 1 ms expressed in ns and in cycles
`define ITFD_CLK_PERIOD_NS 5
`define ITFD_MS_NS         1000000
`define ITFD_CYC_PER_MS    (`ITFD_MS_NS / `ITFD_CLK_PERIOD_NS)

// Terminal function codes
`define ITFD_FN_MREF1    6'd6
`define ITFD_FN_MREF2    6'd7
`define ITFD_FN_MREF3    6'd8
`define ITFD_FN_MREF4    6'd9
`define ITFD_FN_PIDSET   6'd25
`define ITFD_FN_SEQRST   6'd26
`define ITFD_FN_SWING    6'd27
`define ITFD_FN_CNTIN    6'd28
`define ITFD_FN_CNTRST   6'd29
`define ITFD_FN_LENIN    6'd30
`define ITFD_FN_LENRST   6'd31
`define ITFD_FN_FRQLOCK  6'd33
`define ITFD_FN_RAMPHOLD 6'd34
`define ITFD_FN_MOTOR    6'd35
`define ITFD_FN_FLTRST   6'd37
`define ITFD_FN_EXTNO    6'd38
`define ITFD_FN_EXTNC    6'd39
`define ITFD_FN_USR1     6'd40
`define ITFD_FN_USR2     6'd41
`define ITFD_FN_RUNPAUSE 6'd42
`define ITFD_FN_COAST    6'd43
`define ITFD_FN_ESTOP    6'd44
`define ITFD_FN_KEYSTOP  6'd45
`define ITFD_FN_DECSTOP  6'd46
`define ITFD_FN_DCRAMP   6'd47
`define ITFD_FN_DCNOW    6'd48
`define ITFD_FN_RTCLR    6'd49

// Fault codes
`define ITFD_FAULT_NONE 8'h00
`define ITFD_FAULT_EXT  8'd15
`define ITFD_FAULT_USR1 8'd27
`define ITFD_FAULT_USR2 8'd28

`endif

// file: hdl/itfd_dispatch.v
// Input terminal filter, function decoder and request generator with Avalon-MM registers
`timescale 1ns/1ps
`include "itfd_map.vh"

module itfd_dispatch #(
   parameter NUM_TERM    = 12,
   parameter CNT_W       = 16,
   parameter CYC_PER_MS  = `ITFD_CYC_PER_MS
) (
   // Clock, reset, enable
   input  wire                mclk_i,
   input  wire                rst_n_i,
   input  wire                ce_i,
   // Avalon-MM slave
   input  wire [7:0]          avs_address_i,
   input  wire                avs_read_i,
   input  wire                avs_write_i,
   input  wire [31:0]         avs_writedata_i,
   output reg  [31:0]         avs_readdata_o,
   output wire                avs_waitrequest_o,
   // Terminal pins
   input  wire [NUM_TERM-1:0] term_i,
   // Level requests
   output wire                pid_set_secondary_o,
   output wire                swing_pause_o,
   output wire                freq_mod_lock_o,
   output wire                ramp_hold_o,
   output wire                motor_group2_o,
   output wire                run_pause_o,
   output wire                coast_stop_o,
   output wire                emergency_stop_o,
   output wire                decel4_stop_o,
   output wire [3:0]          mref_index_o,
   // Event requests, one cycle each
   output wire                seq_reset_o,
   output wire                fault_reset_o,
   output wire                keypad_stop_o,
   output wire                dc_brake_ramp_o,
   output wire                dc_brake_now_o,
   output wire                run_time_clear_o,
   output wire                fault_raise_o,
   // Fault report and counters
   output reg  [7:0]          fault_code_o,
   output reg  [1:0]          fault_action_o,
   output reg  [CNT_W-1:0]    event_count_o,
   output reg  [CNT_W-1:0]    length_count_o
);

   // ***************************************************
   // Registers and declarations
   // ***************************************************
   reg  [31:0]         ctrl;
   reg  [9:0]          filt_ms;
   reg  [5:0]          func_sel [0:NUM_TERM-1];
   reg                 bus_ack;
   reg  [17:0]         ms_div;
   reg                 ms_tick;
   reg  [NUM_TERM-1:0] sync1;
   reg  [NUM_TERM-1:0] sync2;
   reg  [NUM_TERM-1:0] sync3;
   wire [NUM_TERM-1:0] level;
   reg  [63:0]         fn_act;
   reg  [63:0]         fn_prev;
   reg  [31:0]         next_rdata;
   wire [63:0]         fn_rise;
   wire                bus_req;
   wire                bus_done;
   wire                bus_wr;
   wire [1:0]          cmd_src;
   integer             k;
   integer             j;

   assign bus_req = avs_read_i | avs_write_i;
   // A frozen block must not end a transfer that it cannot complete
   assign bus_done = bus_ack & ce_i;
   // A request waits exactly one cycle, so read data are set up one edge ahead
   assign avs_waitrequest_o = bus_req & ~bus_done;
   assign bus_wr = avs_write_i & bus_done;
   assign cmd_src = ctrl[`ITFD_CTRL_CMDSRC_MSB:`ITFD_CTRL_CMDSRC_LSB];

   // ***************************************************
   // Millisecond time base for the filter
   // ***************************************************
   // Ticks run free, so a filter of n ms waits between n-1 and n ms
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ms_div  <= 18'h00000;
         ms_tick <= 1'b0;
      end else if (ce_i) begin
         if (ms_div >= CYC_PER_MS - 1) begin
            ms_div  <= 18'h00000;
            ms_tick <= 1'b1;
         end else begin
            ms_div  <= ms_div + 18'h00001;
            ms_tick <= 1'b0;
         end
      end
   end

   // ***************************************************
   // Per-terminal synchroniser and filter
   // ***************************************************
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sync1 <= {NUM_TERM{1'b0}};
         sync2 <= {NUM_TERM{1'b0}};
         sync3 <= {NUM_TERM{1'b0}};
      end else if (ce_i) begin
         sync1 <= term_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   genvar t;
   generate
      for (t = 0; t < NUM_TERM; t = t + 1) begin : g_term
         reg [9:0] hold_ms;
         reg       lvl;
         wire      stable_new;
         assign level[t] = lvl;
         // A change only counts once the second and third stage agree
         assign stable_new = (sync2[t] == sync3[t]) && (sync3[t] != lvl);
         always @(posedge mclk_i) begin
            if (!rst_n_i) begin
               lvl     <= 1'b0;
               hold_ms <= 10'h000;
            end else if (ce_i) begin
               // A glitch back clears the hold count, so the filter restarts
               if (!stable_new) begin
                  hold_ms <= 10'h000;
               end else if (hold_ms >= filt_ms) begin
                  lvl     <= sync3[t];
                  hold_ms  <= 10'h000;
               end else if (ms_tick) begin
                  hold_ms <= hold_ms + 10'h001;
               end
            end
         end
      end
   endgenerate

   // ***************************************************
   // Function decode
   // ***************************************************
   // Several terminals may share one function; any active one asserts it
   always @* begin
      fn_act = 64'h0;
      for (k = 0; k < NUM_TERM; k = k + 1) begin
         if (level[k]) begin
            fn_act = fn_act | (64'h1 << func_sel[k]);
         end
      end
      // Reserved codes 32 and 36 are simply never consumed below
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fn_prev <= 64'h0;
      end else if (ce_i) begin
         fn_prev <= fn_act;
      end
   end

   // Gated by the enable so that a frozen block issues no pulse
   assign fn_rise = fn_act & ~fn_prev & {64{ce_i}};

   // ***************************************************
   // Level requests
   // ***************************************************
   assign pid_set_secondary_o = ctrl[`ITFD_CTRL_PIDSRC] & fn_act[`ITFD_FN_PIDSET];
   assign swing_pause_o       = fn_act[`ITFD_FN_SWING];
   assign freq_mod_lock_o     = fn_act[`ITFD_FN_FRQLOCK];
   // A run pause, coast, emergency or decel stop releases the hold so that it can ramp down
   assign ramp_hold_o         = fn_act[`ITFD_FN_RAMPHOLD] & ~(run_pause_o | coast_stop_o
                                | emergency_stop_o | decel4_stop_o);
   assign motor_group2_o      = fn_act[`ITFD_FN_MOTOR];
   assign run_pause_o         = fn_act[`ITFD_FN_RUNPAUSE];
   assign coast_stop_o        = fn_act[`ITFD_FN_COAST];
   assign emergency_stop_o    = fn_act[`ITFD_FN_ESTOP];
   assign decel4_stop_o       = fn_act[`ITFD_FN_DECSTOP];
   assign mref_index_o        = {fn_act[`ITFD_FN_MREF4], fn_act[`ITFD_FN_MREF3],
                                 fn_act[`ITFD_FN_MREF2], fn_act[`ITFD_FN_MREF1]};

   // ***************************************************
   // Event requests
   // ***************************************************
   assign seq_reset_o      = fn_rise[`ITFD_FN_SEQRST];
   assign fault_reset_o    = fn_rise[`ITFD_FN_FLTRST];
   assign keypad_stop_o    = fn_rise[`ITFD_FN_KEYSTOP]
                             & (cmd_src == `ITFD_CMDSRC_KEYPAD);
   assign dc_brake_ramp_o  = fn_rise[`ITFD_FN_DCRAMP];
   assign dc_brake_now_o   = fn_rise[`ITFD_FN_DCNOW];
   assign run_time_clear_o = fn_rise[`ITFD_FN_RTCLR] & ctrl[`ITFD_CTRL_RTA]
                             & ctrl[`ITFD_CTRL_RTB];
   assign fault_raise_o    = fn_rise[`ITFD_FN_EXTNO] | fn_rise[`ITFD_FN_EXTNC]
                             | fn_rise[`ITFD_FN_USR1] | fn_rise[`ITFD_FN_USR2];

   // ***************************************************
   // Fault capture
   // ***************************************************
   // A new fault in the reset cycle wins over the reset
   // External beats user 1, which beats user 2, when they rise together
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fault_code_o   <= `ITFD_FAULT_NONE;
         fault_action_o <= 2'h0;
      end else if (ce_i) begin
         if (fn_rise[`ITFD_FN_EXTNO] | fn_rise[`ITFD_FN_EXTNC]) begin
            fault_code_o   <= `ITFD_FAULT_EXT;
            fault_action_o <= ctrl[`ITFD_CTRL_EXTACT_MSB:`ITFD_CTRL_EXTACT_LSB];
         end else if (fn_rise[`ITFD_FN_USR1]) begin
            fault_code_o   <= `ITFD_FAULT_USR1;
            fault_action_o <= ctrl[`ITFD_CTRL_USRACT_MSB:`ITFD_CTRL_USRACT_LSB];
         end else if (fn_rise[`ITFD_FN_USR2]) begin
            fault_code_o   <= `ITFD_FAULT_USR2;
            fault_action_o <= ctrl[`ITFD_CTRL_USRACT_MSB:`ITFD_CTRL_USRACT_LSB];
         end else if (fault_reset_o) begin
            fault_code_o   <= `ITFD_FAULT_NONE;
            fault_action_o <= 2'h0;
         end
      end
   end

   // ***************************************************
   // Event and length counters
   // ***************************************************
   // Counters wrap; the clear terminal is a level and holds them at zero
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         event_count_o  <= {CNT_W{1'b0}};
         length_count_o <= {CNT_W{1'b0}};
      end else if (ce_i) begin
         if (fn_act[`ITFD_FN_CNTRST]) begin
            event_count_o <= {CNT_W{1'b0}};
         end else if (fn_rise[`ITFD_FN_CNTIN]) begin
            event_count_o <= event_count_o + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (fn_act[`ITFD_FN_LENRST]) begin
            length_count_o <= {CNT_W{1'b0}};
         end else if (fn_rise[`ITFD_FN_LENIN]) begin
            length_count_o <= length_count_o + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ***************************************************
   // Register bus
   // ***************************************************
   // Unmapped offsets read as zero
   always @* begin
      next_rdata = 32'h0000_0000;
      case (avs_address_i)
         `ITFD_OFS_CTRL:   next_rdata = ctrl;
         `ITFD_OFS_FILTER: next_rdata = {22'h0, filt_ms};
         `ITFD_OFS_LEVELS: next_rdata[NUM_TERM-1:0] = level;
         `ITFD_OFS_EVCNT:  next_rdata[CNT_W-1:0] = event_count_o;
         `ITFD_OFS_LENGTH: next_rdata[CNT_W-1:0] = length_count_o;
         `ITFD_OFS_FAULT:  next_rdata = {22'h0, fault_action_o, fault_code_o};
         `ITFD_OFS_REQS:   next_rdata = {18'h0, mref_index_o, decel4_stop_o,
                                         emergency_stop_o, coast_stop_o, run_pause_o,
                                         motor_group2_o, ramp_hold_o, freq_mod_lock_o,
                                         swing_pause_o, pid_set_secondary_o, 1'b0};
         default: begin
            for (j = 0; j < NUM_TERM; j = j + 1) begin
               if (avs_address_i == `ITFD_OFS_FSEL_BASE + j[7:0] * 8'h04) begin
                  next_rdata = {26'h0, func_sel[j]};
               end
            end
         end
      endcase
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bus_ack        <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         bus_ack <= bus_req & ~bus_ack;
         if (avs_read_i & ~bus_ack) begin
            avs_readdata_o <= next_rdata;
         end
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ctrl    <= `ITFD_CTRL_RESET;
         filt_ms <= `ITFD_FILT_MS_RESET;
      end else if (bus_wr) begin
         if (avs_address_i == `ITFD_OFS_CTRL) begin
            // Masked so that undefined control bits always read back as zero
            ctrl <= avs_writedata_i & 32'h0000_0f1f;
         end
         if (avs_address_i == `ITFD_OFS_FILTER) begin
            // Values beyond one second saturate to the ceiling
            filt_ms <= (avs_writedata_i[31:10] != 22'h0 ||
                        avs_writedata_i[9:0] > `ITFD_FILT_MS_MAX) ?
                       `ITFD_FILT_MS_MAX : avs_writedata_i[9:0];
         end
      end
   end

   generate
      for (t = 0; t < NUM_TERM; t = t + 1) begin : g_fsel
         wire fsel_hit;
         assign fsel_hit = (avs_address_i == `ITFD_OFS_FSEL_BASE + t * 4);
         always @(posedge mclk_i) begin
            if (!rst_n_i) begin
               func_sel[t] <= 6'h00;
            end else if (bus_wr && fsel_hit) begin
               func_sel[t] <= avs_writedata_i[5:0];
            end
         end
      end
   endgenerate

endmodule

// file: verif/itfd_dispatch_sva.sv
// Port checker for the terminal dispatcher
`timescale 1ns/1ps
module itfd_dispatch_sva #(
   parameter CNT_W = 16
) (
   // Clock, reset, bus handshake
   input wire             mclk_i,
   input wire             rst_n_i,
   input wire             ce_i,
   input wire             avs_read_i,
   input wire             avs_write_i,
   input wire             avs_waitrequest_o,
   // Requests and counters
   input wire             ramp_hold_o,
   input wire             run_pause_o,
   input wire             coast_stop_o,
   input wire             emergency_stop_o,
   input wire             decel4_stop_o,
   input wire             seq_reset_o,
   input wire             fault_reset_o,
   input wire             dc_brake_now_o,
   input wire             fault_raise_o,
   input wire [7:0]       fault_code_o,
   input wire [CNT_W-1:0] event_count_o,
   input wire [CNT_W-1:0] length_count_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   a_bus_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
      |=> !avs_waitrequest_o || !ce_i) else $error("bus answer not after one wait cycle");
   a_bus_idle_ready: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest high with no request");
   a_hold_yields_stop: assert property (ramp_hold_o |->
      !(run_pause_o || coast_stop_o || emergency_stop_o || decel4_stop_o))
      else $error("ramp hold kept during stop");
   a_seq_single_pulse: assert property (seq_reset_o |=> !seq_reset_o)
      else $error("sequencer reset longer than one cycle");
   a_reset_single_pulse: assert property ($rose(fault_reset_o) |=> $fell(fault_reset_o))
      else $error("fault reset longer than one cycle");
   a_dcnow_single_pulse: assert property (dc_brake_now_o ##1 !dc_brake_now_o |->
      !dc_brake_now_o [*2]) else $error("braking pulse repeats while held");
   a_fault_code_set: assert property (fault_raise_o |=>
      fault_code_o == 8'h0f || fault_code_o == 8'h1b || fault_code_o == 8'h1c)
      else $error("fault raised, bad code");
   a_count_step: assert property ($changed(event_count_o) |->
      event_count_o == '0 || event_count_o == $past(event_count_o) + 1'b1)
      else $error("event count jumped");
   a_length_step: assert property ($changed(length_count_o) |->
      length_count_o == '0 || length_count_o == $past(length_count_o) + 1'b1)
      else $error("length jumped");
   a_enable_freeze: assert property (!ce_i |=> $stable(event_count_o)
      && $stable(length_count_o) && $stable(fault_code_o))
      else $error("state moved while disabled");
endmodule

bind itfd_dispatch itfd_dispatch_sva #(.CNT_W(CNT_W)) u_sva (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .ramp_hold_o(ramp_hold_o), .run_pause_o(run_pause_o), .coast_stop_o(coast_stop_o),
   .emergency_stop_o(emergency_stop_o), .decel4_stop_o(decel4_stop_o),
   .seq_reset_o(seq_reset_o), .fault_reset_o(fault_reset_o), .dc_brake_now_o(dc_brake_now_o),
   .fault_raise_o(fault_raise_o), .fault_code_o(fault_code_o),
   .event_count_o(event_count_o), .length_count_o(length_count_o));

// file: verif/itfd_term_model.sv
// Behavioural bank of switches driving the terminal pins
`timescale 1ns/1ps
module itfd_term_model #(
   parameter NUM_TERM = 12
) (
   // Clock
   input  wire                mclk_i,
   // Pins towards the dispatcher
   output reg  [NUM_TERM-1:0] term_o
);
   initial term_o = '0;
   // Contacts move just after an edge so no pin races the sampling flop
   task set_pin(input integer idx, input reg val);
      @(posedge mclk_i);
      term_o[idx] <= val;
   endtask
   task set_all(input [NUM_TERM-1:0] val);
      @(posedge mclk_i);
      term_o <= val;
   endtask
endmodule

// file: verif/itfd_dispatch_test.sv
// Self-checking bench for the terminal dispatcher
`timescale 1ns/1ps
`include "itfd_map.vh"
module itfd_dispatch_test;
   reg         mclk_i;
   reg         rst_n_i;
   reg         ce_i;
   reg  [7:0]  adr;
   reg         rd_en;
   reg         wr_en;
   reg  [31:0] wdat;
   wire [31:0] rdat;
   wire        wait_o;
   wire [11:0] term;
   wire [9:1]  lv;
   wire [3:0]  mref;
   wire [5:0]  ev;
   wire        fraise;
   wire [7:0]  fcode;
   wire [1:0]  fact;
   wire [15:0] evc;
   wire [15:0] lenc;
   integer     n_fail = 0;
   integer     num_checks = 0;
   integer     cyc = 0;
   localparam [53:0] LV_FN = {`ITFD_FN_DECSTOP, `ITFD_FN_ESTOP, `ITFD_FN_COAST,
      `ITFD_FN_RUNPAUSE, `ITFD_FN_MOTOR, `ITFD_FN_RAMPHOLD, `ITFD_FN_FRQLOCK,
      `ITFD_FN_SWING, `ITFD_FN_PIDSET};
   localparam [35:0] EV_FN = {`ITFD_FN_RTCLR, `ITFD_FN_DCNOW, `ITFD_FN_DCRAMP,
      `ITFD_FN_KEYSTOP, `ITFD_FN_FLTRST, `ITFD_FN_SEQRST};
   localparam [31:0] FC = {`ITFD_FAULT_USR2, `ITFD_FAULT_USR1, `ITFD_FAULT_EXT, `ITFD_FAULT_EXT};

   itfd_term_model u_term (.mclk_i(mclk_i), .term_o(term));
   itfd_dispatch #(.CYC_PER_MS(10)) u_dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(adr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .term_i(term),
      .pid_set_secondary_o(lv[1]), .swing_pause_o(lv[2]), .freq_mod_lock_o(lv[3]),
      .ramp_hold_o(lv[4]), .motor_group2_o(lv[5]), .run_pause_o(lv[6]),
      .coast_stop_o(lv[7]), .emergency_stop_o(lv[8]), .decel4_stop_o(lv[9]),
      .mref_index_o(mref), .seq_reset_o(ev[0]), .fault_reset_o(ev[1]),
      .keypad_stop_o(ev[2]), .dc_brake_ramp_o(ev[3]), .dc_brake_now_o(ev[4]),
      .run_time_clear_o(ev[5]), .fault_raise_o(fraise), .fault_code_o(fcode),
      .fault_action_o(fact), .event_count_o(evc), .length_count_o(lenc));

   // ****************************************
   // Shared tasks
   // ****************************************
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // A hang anywhere ends here rather than running forever
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         summarize;
      end
   end
   task chk(input string what, input [31:0] seen, input [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         n_fail = n_fail + 1;
      end
   endtask
   task bus(input reg w, input [7:0] a, input [31:0] d, output [31:0] q);
      @(posedge mclk_i);
      rd_en <= ~w;
      wr_en <= w;
      adr <= a;
      wdat <= d;
      @(posedge mclk_i);
      while (wait_o !== 1'b0) @(posedge mclk_i);
      q = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      reg [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rd(input [7:0] a, output [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task fsel(input integer i, input [5:0] fn);
      wr(`ITFD_OFS_FSEL_BASE + 8'(4 * i), {26'h0, fn});
   endtask
   task tap(input integer i, input integer n);
      repeat (n) begin
         u_term.set_pin(i, 1'b1);
         repeat (5) @(posedge mclk_i);
         u_term.set_pin(i, 1'b0);
         repeat (5) @(posedge mclk_i);
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_regs;
      reg [31:0] q;
      rd(`ITFD_OFS_FILTER, q);
      chk("filter reset", q, {22'h0, `ITFD_FILT_MS_RESET});
      wr(`ITFD_OFS_FILTER, 32'h0000_07d0);
      rd(`ITFD_OFS_FILTER, q);
      chk("filter ceiling", q, {22'h0, `ITFD_FILT_MS_MAX});
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, q);
      chk("unmapped", q, 32'h0);
      wr(`ITFD_OFS_FILTER, 32'h0000_0002);
      fsel(0, `ITFD_FN_MOTOR);
      u_term.set_pin(0, 1'b1);
      repeat (8) @(posedge mclk_i);
      chk("filtered early", lv[5], 1'b0);
      repeat (40) @(posedge mclk_i);
      chk("filtered late", lv[5], 1'b1);
      u_term.set_pin(0, 1'b0);
      wr(`ITFD_OFS_FILTER, 32'h0);
      $display("test regs done");
   endtask
   task t_levels;
      reg [31:0] q;
      integer k;
      wr(`ITFD_OFS_CTRL, 32'h4);
      for (k = 0; k < 9; k = k + 1) begin
         fsel(0, LV_FN[k*6 +: 6]);
         u_term.set_pin(0, 1'b1);
         repeat (6) @(posedge mclk_i);
         rd(`ITFD_OFS_REQS, q);
         chk("request bits", q, 32'h1 << (k + 1));
         chk("request pins", {lv, 1'b0}, 10'h1 << (k + 1));
         u_term.set_pin(0, 1'b0);
      end
      fsel(0, `ITFD_FN_RAMPHOLD);
      fsel(1, `ITFD_FN_COAST);
      u_term.set_all(12'h003);
      repeat (6) @(posedge mclk_i);
      chk("hold and coast", {lv, 1'b0}, 10'h080);
      wr(`ITFD_OFS_CTRL, 32'h0);
      fsel(0, `ITFD_FN_PIDSET);
      fsel(1, 6'd32);
      repeat (6) @(posedge mclk_i);
      chk("pid off, reserved", {lv, 1'b0}, 10'h0);
      u_term.set_all(12'h0);
      $display("test levels done");
   endtask
   task t_mref;
      integer v;
      for (v = 0; v < 4; v = v + 1) fsel(v, `ITFD_FN_MREF1 + 6'(v));
      for (v = 0; v < 16; v = v + 1) begin
         u_term.set_all(12'(v));
         repeat (6) @(posedge mclk_i);
         chk("mref index", mref, v[3:0]);
      end
      u_term.set_all(12'h0);
      $display("test mref done");
   endtask
   task pulses(input integer k, input [31:0] exp);
      integer i;
      integer n;
      n = 0;
      fsel(0, EV_FN[k*6 +: 6]);
      u_term.set_pin(0, 1'b1);
      for (i = 0; i < 12; i = i + 1) begin
         @(posedge mclk_i);
         if (ev[k] === 1'b1) n = n + 1;
      end
      u_term.set_pin(0, 1'b0);
      repeat (6) @(posedge mclk_i);
      chk("event pulses", n, exp);
   endtask
   task t_events;
      integer k;
      wr(`ITFD_OFS_CTRL, 32'h18);
      for (k = 0; k < 6; k = k + 1) pulses(k, 1);
      wr(`ITFD_OFS_CTRL, 32'h09);
      pulses(2, 0);
      pulses(5, 0);
      $display("test events done");
   endtask
   task t_counters;
      fsel(0, `ITFD_FN_CNTIN);
      fsel(1, `ITFD_FN_CNTRST);
      fsel(2, `ITFD_FN_LENIN);
      fsel(3, `ITFD_FN_LENRST);
      tap(0, 3);
      chk("event count", evc, 3);
      tap(2, 5);
      chk("length", lenc, 5);
      u_term.set_pin(1, 1'b1);
      tap(0, 2);
      chk("count held clear", evc, 0);
      u_term.set_pin(3, 1'b1);
      repeat (6) @(posedge mclk_i);
      chk("length clear", lenc, 0);
      u_term.set_all(12'h0);
      tap(0, 1);
      chk("count resumes", evc, 1);
      $display("test counters done");
   endtask
   task t_faults;
      integer k;
      wr(`ITFD_OFS_CTRL, 32'h0600);
      for (k = 0; k < 4; k = k + 1) fsel(k, `ITFD_FN_EXTNO + 6'(k));
      fsel(4, `ITFD_FN_FLTRST);
      for (k = 0; k < 4; k = k + 1) begin
         tap(k, 1);
         chk("fault code", fcode, FC[k*8 +: 8]);
         chk("fault action", fact, (k < 2) ? 2'h2 : 2'h1);
         tap(4, 1);
         chk("fault cleared", fcode, `ITFD_FAULT_NONE);
      end
      $display("test faults done");
   endtask
   // Pins toggled while frozen must leave no trace once the block runs again
   task t_enable;
      fsel(0, `ITFD_FN_CNTIN);
      @(posedge mclk_i);
      ce_i <= 1'b0;
      tap(0, 2);
      chk("frozen count", evc, 32'h1);
      @(posedge mclk_i);
      ce_i <= 1'b1;
      tap(0, 1);
      chk("count after enable", evc, 32'h2);
      $display("test enable done");
   endtask
   task t_reset;
      reg [31:0] q;
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(`ITFD_OFS_CTRL, q);
      chk("ctrl after reset", q, `ITFD_CTRL_RESET);
      rd(`ITFD_OFS_FILTER, q);
      chk("filter after reset", q, {22'h0, `ITFD_FILT_MS_RESET});
      chk("count after reset", evc, 32'h0);
      $display("test reset done");
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      adr = 8'h0;
      rd_en = 1'b0;
      wr_en = 1'b0;
      wdat = 32'h0;
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_levels;
      t_mref;
      t_events;
      t_counters;
      t_faults;
      t_enable;
      t_reset;
      summarize;
   end
endmodule
